// *** pin_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: Output follows only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

   // First stage feeds only the second stage
   always_comb begin
      out_d = out_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         out_q <= INIT;
      end else begin
         s1_q <= async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign synced = out_q;
endmodule : pin_sync

// *** spi_frame_decoder.sv ***
// Purpose: Device-side decoder of mode-0 serial register-access frames.
// Assumes: Serial clock is far slower than ref_clk and is oversampled.
// Notes: Read data come from TXDATA, written bytes leave on rxByte.
// What this block does
// - Header bit seven selects read or write
// - Size field counts bytes minus one, 1..64
// - Size bits five..zero are wire bits 2..7
// - Address bits 23..0 follow, msb first
// - Wait states only between address and data
// - Data least significant byte first, msb first
// - Written bytes map lowest byte first, lowest offset
// - Payload bytes pass through in arrival order
// - Launch on falling edge, sample on rising
// - Low in window waits, high ends waiting
// - Only frames in D4 window are served
// - Short write sets the data expected flag
`timescale 1ns/1ps
module spi_frame_decoder #(
   parameter int WAIT_WIDTH = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire spi_frame_pkg::pins_s pins,
   output logic miso,
   output logic misoOe,
   output spi_frame_pkg::rx_byte_s rxByte,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [31:0] rdData
);
   typedef enum logic [2:0] {IDLE, HEAD, WAITST, DATA, DONE} state_e;

   logic [2:0] pinsS;
   logic csHigh, sclkS, mosiS, sclkPrev_q, rise, fall;
   state_e st_q, st_d;
   logic [4:0] bitCnt_q, bitCnt_d;
   logic [30:0] hdr_q, hdr_d;
   logic [5:0] size_q, size_d;
   logic [23:0] addr_q, addr_d;
   logic isRead_q, isRead_d;
   logic [2:0] waitBit_q, waitBit_d;
   logic [WAIT_WIDTH-1:0] waitLeft_q, waitLeft_d;
   logic [6:0] byteIdx_q, byteIdx_d;
   logic [7:0] rxSh_q, rxSh_d;
   logic [31:0] rxWord_q, rxWord_d;
   logic miso_q, miso_d, oe_q, oe_d;
   spi_frame_pkg::rx_byte_s rx_q, rx_d;
   logic expSet;
   logic [7:0] curByte;
   logic [WAIT_WIDTH-1:0] waitCfg_q, waitCfg_d;
   logic [31:0] tx_q, tx_d, rd_q, rd_d;
   logic exp_q, exp_d;

   pin_sync #(.WIDTH(3), .INIT(3'h4)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async(pins),
      .synced(pinsS)
   );
   assign csHigh = pinsS[2];
   assign sclkS = pinsS[1];
   assign mosiS = pinsS[0];
   assign rise = sclkS & ~sclkPrev_q;
   assign fall = ~sclkS & sclkPrev_q;
   assign curByte = tx_q[{byteIdx_q[1:0], 3'h0} +: 8];

   // Link frame state
   always_comb begin
      st_d = st_q;
      bitCnt_d = bitCnt_q;
      hdr_d = hdr_q;
      size_d = size_q;
      addr_d = addr_q;
      isRead_d = isRead_q;
      waitBit_d = waitBit_q;
      waitLeft_d = waitLeft_q;
      byteIdx_d = byteIdx_q;
      rxSh_d = rxSh_q;
      rxWord_d = rxWord_q;
      miso_d = miso_q;
      oe_d = oe_q;
      rx_d = rx_q;
      rx_d.valid = 1'b0;
      expSet = 1'b0;
      if (csHigh) begin
         // Partial frames are abandoned at once; bytes already completed stay delivered
         st_d = IDLE;
         oe_d = 1'b0;
         miso_d = 1'b0;
         bitCnt_d = '0;
         expSet = (st_q == WAITST || st_q == DATA) && !isRead_q;
      end else begin
         unique case (st_q)
            IDLE: begin
               st_d = HEAD;
               bitCnt_d = '0;
            end
            HEAD: begin
               if (rise) begin
                  hdr_d = {hdr_q[29:0], mosiS};
                  bitCnt_d = bitCnt_q + 5'h1;
                  if (bitCnt_q == spi_frame_pkg::LAST_ADDR_BIT) begin
                     isRead_d = hdr_q[spi_frame_pkg::HDR_DIR];
                     size_d = hdr_q[spi_frame_pkg::HDR_SIZE_HI:spi_frame_pkg::HDR_SIZE_LO];
                     addr_d = {hdr_q[spi_frame_pkg::HDR_WIN_HI:0], mosiS};
                     if (hdr_q[spi_frame_pkg::HDR_WIN_HI:spi_frame_pkg::HDR_WIN_LO]
                         == spi_frame_pkg::OWN_WINDOW) begin
                        st_d = WAITST;
                        oe_d = 1'b1;
                        miso_d = 1'b1;
                        waitBit_d = '0;
                        waitLeft_d = waitCfg_q;
                     end else begin
                        st_d = DONE;
                     end
                  end
               end
            end
            WAITST: begin
               if (fall && waitBit_q == '0) begin
                  miso_d = (waitLeft_q == '0);
               end
               if (rise) begin
                  if (waitBit_q == '0 && miso_q) begin
                     st_d = DATA;
                     bitCnt_d = '0;
                     byteIdx_d = '0;
                  end else begin
                     // Window repeats every eight clocks while waiting
                     waitBit_d = waitBit_q + 3'h1;
                     if (waitBit_q == '0) begin
                        waitLeft_d = waitLeft_q - 1'b1;
                     end
                  end
               end
            end
            DATA: begin
               if (fall && isRead_q) begin
                  miso_d = curByte[spi_frame_pkg::BYTE_LAST_BIT - bitCnt_q[2:0]];
               end
               if (rise) begin
                  rxSh_d = {rxSh_q[6:0], mosiS};
                  bitCnt_d = bitCnt_q + 5'h1;
                  if (bitCnt_q[2:0] == spi_frame_pkg::BYTE_LAST_BIT) begin
                     byteIdx_d = byteIdx_q + 7'h1;
                     if (!isRead_q) begin
                        rx_d.valid = 1'b1;
                        rx_d.index = byteIdx_q[5:0];
                        rx_d.data = {rxSh_q[6:0], mosiS};
                        rxWord_d[{byteIdx_q[1:0], 3'h0} +: 8] = {rxSh_q[6:0], mosiS};
                     end
                     if (byteIdx_q[5:0] == size_q) begin
                        st_d = DONE;
                     end
                  end
               end
            end
            DONE: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclkPrev_q <= 1'b0;
         st_q <= IDLE;
         bitCnt_q <= '0;
         hdr_q <= '0;
         size_q <= '0;
         addr_q <= '0;
         isRead_q <= 1'b0;
         waitBit_q <= '0;
         waitLeft_q <= '0;
         byteIdx_q <= '0;
         rxSh_q <= '0;
         rxWord_q <= '0;
         miso_q <= 1'b0;
         oe_q <= 1'b0;
         rx_q <= '0;
      end else begin
         sclkPrev_q <= sclkS;
         st_q <= st_d;
         bitCnt_q <= bitCnt_d;
         hdr_q <= hdr_d;
         size_q <= size_d;
         addr_q <= addr_d;
         isRead_q <= isRead_d;
         waitBit_q <= waitBit_d;
         waitLeft_q <= waitLeft_d;
         byteIdx_q <= byteIdx_d;
         rxSh_q <= rxSh_d;
         rxWord_q <= rxWord_d;
         miso_q <= miso_d;
         oe_q <= oe_d;
         rx_q <= rx_d;
      end
   end

   // Register port; read data stand only in the cycle after the strobe
   always_comb begin
      waitCfg_d = waitCfg_q;
      tx_d = tx_q;
      rd_d = '0;
      // Hardware set beats a simultaneous software clear
      exp_d = expSet | exp_q;
      if (wrStb) begin
         unique case (regAddr)
            spi_frame_pkg::REG_CTRL: waitCfg_d = wrData[WAIT_WIDTH-1:0];
            spi_frame_pkg::REG_STATUS: exp_d = expSet | (exp_q & ~wrData[spi_frame_pkg::ST_EXPECT]);
            spi_frame_pkg::REG_TXDATA: tx_d = wrData;
            default: ;
         endcase
      end
      if (rdStb) begin
         unique case (regAddr)
            spi_frame_pkg::REG_CTRL: rd_d[WAIT_WIDTH-1:0] = waitCfg_q;
            spi_frame_pkg::REG_STATUS: begin
               rd_d[spi_frame_pkg::ST_EXPECT] = exp_q;
               rd_d[spi_frame_pkg::ST_BUSY] = (st_q != IDLE);
               rd_d[spi_frame_pkg::ST_READ] = isRead_q;
               rd_d[spi_frame_pkg::ST_SIZE_LO +: 6] = size_q;
            end
            spi_frame_pkg::REG_ADDR: rd_d[23:0] = addr_q;
            spi_frame_pkg::REG_TXDATA: rd_d = tx_q;
            spi_frame_pkg::REG_RXDATA: rd_d = rxWord_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         waitCfg_q <= spi_frame_pkg::CTRL_RESET[WAIT_WIDTH-1:0];
         tx_q <= spi_frame_pkg::TXDATA_RESET;
         rd_q <= '0;
         exp_q <= 1'b0;
      end else begin
         waitCfg_q <= waitCfg_d;
         tx_q <= tx_d;
         rd_q <= rd_d;
         exp_q <= exp_d;
      end
   end

   assign miso = miso_q;
   assign misoOe = oe_q;
   assign rxByte = rx_q;
   assign rdData = rd_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_last_addr;
      st_q == HEAD && !csHigh && rise && bitCnt_q == spi_frame_pkg::LAST_ADDR_BIT;
   endsequence
   sequence s_wait_release;
      st_q == WAITST && !csHigh && fall && waitBit_q == '0 && waitLeft_q == '0;
   endsequence

   chk_header_fields: assert property (s_last_addr |=>
      isRead_q == $past(hdr_q[30]) && size_q == $past(hdr_q[28:23])
      && addr_q == {$past(hdr_q[22:0]), $past(mosiS)})
      else $error("header fields not captured");
   chk_window_entry: assert property (s_last_addr ##1 st_q == WAITST
      |-> addr_q[23:16] == spi_frame_pkg::OWN_WINDOW && misoOe)
      else $error("wait entered outside own window");
   chk_wait_release: assert property (s_wait_release |=> miso)
      else $error("no-wait bit not driven high");
   chk_wait_hold: assert property (st_q == WAITST && !csHigh && fall && waitBit_q == '0
      && waitLeft_q != '0 |=> !miso)
      else $error("wait bit not driven low");
   chk_data_entry: assert property (st_q == DATA && $past(st_q) != DATA
      |-> $past(st_q) == WAITST && $past(miso))
      else $error("data phase entered without wait window");
   chk_launch_edge: assert property (misoOe && $past(misoOe) && $changed(miso)
      |-> $past(fall))
      else $error("output changed off falling edge");
   chk_byte_order: assert property (rxByte.valid |-> rxByte.index == byteIdx_q[5:0] - 6'h1
      && rxWord_q[{rxByte.index[1:0], 3'h0} +: 8] == rxByte.data)
      else $error("payload byte order broken");
   chk_rx_pulse: assert property (rxByte.valid |=> !rxByte.valid)
      else $error("byte strobe longer than one cycle");
   chk_frame_end: assert property (st_q == DATA && !csHigh && rise && bitCnt_q[2:0] == 3'h7
      && byteIdx_q[5:0] == size_q |=> st_q == DONE)
      else $error("frame did not end after counted bytes");
   chk_abandon: assert property (csHigh && st_q != IDLE |=> st_q == IDLE && !misoOe)
      else $error("deselect did not abandon frame");
   chk_expect_set: assert property (csHigh && (st_q == WAITST || st_q == DATA)
      && !isRead_q |=> exp_q)
      else $error("short write left expect flag clear");
endmodule : spi_frame_decoder

// *** spi_frame_decoder_tb_top.sv ***
// Purpose: Self-checking bench for the serial frame decoder.
// Assumes: Host model drives the link at a 125 ns period.
// Notes: Expected bytes come from the host transmit buffer and txWord.
`timescale 1ns/1ps
module spi_frame_decoder_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] wrData = 32'h0000_0000;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic [31:0] rdData;
   logic miso, misoOe, hCs, hClk, hMosi;
   spi_frame_pkg::pins_s pins;
   spi_frame_pkg::rx_byte_s rxByte;
   int fail_count = 0;
   int cmp_count = 0;
   int rxData[$];
   int rxIndex[$];
   logic oeSeen = 1'b0;
   logic [31:0] got, txWord;
   logic [31:0] rxModel = 32'h0000_0000;
   logic [23:0] addr;
   logic [5:0] sz;

   always #2 ref_clk = ~ref_clk;
   assign pins = '{csN: hCs, sclk: hClk, mosi: hMosi};

   spi_frame_decoder dut_u (.ref_clk(ref_clk), .rst(rst), .pins(pins), .miso(miso),
      .misoOe(misoOe), .rxByte(rxByte), .regAddr(regAddr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
   spi_host_model host_u (.csN(hCs), .sclk(hClk), .mosi(hMosi), .miso(miso),
      .misoOe(misoOe));

   always @(posedge ref_clk) begin
      if (rxByte.valid === 1'b1) begin
         rxData.push_back(rxByte.data);
         rxIndex.push_back(rxByte.index);
      end
      if (misoOe === 1'b1) oeSeen = 1'b1;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic regWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      wrStb <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge ref_clk);
      wrStb <= 1'b0;
   endtask : regWr

   task automatic regRd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      rdStb <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask : regRd

   task automatic writeFrame(input logic [5:0] s, input logic [23:0] a, input int stopAt);
      for (int k = 0; k < 64; k++) host_u.txBuf[k] = 8'($urandom);
      rxData.delete();
      rxIndex.delete();
      host_u.frame(1'b0, s, a, stopAt);
      repeat (20) @(posedge ref_clk);
   endtask : writeFrame

   task automatic test_done;
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   initial begin
      #380000;
      fail_count++;
      test_done();
   end

   initial begin
      void'($urandom(32'h0369a73f));
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      regRd(spi_frame_pkg::REG_CTRL, got);
      chk(got, 32'(spi_frame_pkg::CTRL_RESET));
      regRd(spi_frame_pkg::REG_TXDATA, got);
      chk(got, spi_frame_pkg::TXDATA_RESET);
      regRd(8'hfc, got);
      chk(got, 32'h0000_0000);
      regWr(spi_frame_pkg::REG_CTRL, 32'h0000_0002);
      regRd(spi_frame_pkg::REG_CTRL, got);
      chk(got, 32'h0000_0002);
      regWr(spi_frame_pkg::REG_CTRL, 32'h0000_0000);
      $display("test registers done");
      for (int t = 0; t < 3; t++) begin
         sz = (t == 0) ? 6'h00 : (t == 1) ? 6'(1 + $urandom % 62) : 6'h3f;
         addr = {spi_frame_pkg::OWN_WINDOW, 16'($urandom)};
         writeFrame(sz, addr, 100000);
         chk(rxData.size(), sz + 1);
         for (int k = 0; k < rxData.size(); k++) begin
            chk(rxData[k], host_u.txBuf[k]);
            chk(rxIndex[k], k);
         end
         regRd(spi_frame_pkg::REG_STATUS, got);
         chk(got & 32'h0000_3f07, {18'h0, sz, 8'h00});
         regRd(spi_frame_pkg::REG_ADDR, got);
         chk(got & 32'h00ff_ffff, {8'h00, addr});
         for (int k = 0; k <= sz; k++) rxModel[8 * (k % 4) +: 8] = host_u.txBuf[k];
         regRd(spi_frame_pkg::REG_RXDATA, got);
         chk(got, rxModel);
      end
      $display("test writes done");
      txWord = $urandom;
      regWr(spi_frame_pkg::REG_TXDATA, txWord);
      regWr(spi_frame_pkg::REG_CTRL, 32'h0000_0002);
      host_u.frame(1'b1, 6'h05, {spi_frame_pkg::OWN_WINDOW, 16'h0010}, 100000);
      chk(host_u.waitCount, 2);
      for (int k = 0; k < 6; k++) chk(host_u.rxBuf[k], txWord[8 * (k % 4) +: 8]);
      regRd(spi_frame_pkg::REG_STATUS, got);
      chk(got & 32'h0000_3f07, 32'h0000_0504);
      regWr(spi_frame_pkg::REG_CTRL, 32'h0000_0000);
      $display("test read done");
      oeSeen = 1'b0;
      writeFrame(6'h00, 24'h12_3456, 40);
      chk(oeSeen, 1'b0);
      chk(rxData.size(), 0);
      $display("test window done");
      writeFrame(6'h03, {spi_frame_pkg::OWN_WINDOW, 16'h0024}, 37);
      chk(rxData.size(), 0);
      regRd(spi_frame_pkg::REG_STATUS, got);
      chk(got & 32'h0000_0003, 32'h0000_0001);
      regWr(spi_frame_pkg::REG_STATUS, 32'h0000_0001);
      regRd(spi_frame_pkg::REG_STATUS, got);
      chk(got & 32'h0000_0001, 32'h0000_0000);
      writeFrame(6'h01, {spi_frame_pkg::OWN_WINDOW, 16'h0024}, 100000);
      chk(rxData.size(), 2);
      chk(rxData[0], host_u.txBuf[0]);
      $display("test abort done");
      test_done();
   end
endmodule : spi_frame_decoder_tb_top

// *** spi_frame_pkg.sv ***
// Purpose: Shared constants and carriers for the serial transaction frame decoder.
// Assumes: Register bus with 8-bit byte addresses and 32-bit words.
// Notes: All offsets are byte addresses of aligned words.
package spi_frame_pkg;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_TXDATA = 8'h0c;
   localparam logic [7:0] REG_RXDATA = 8'h10;
   // Status field positions
   localparam int ST_EXPECT = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_READ = 2;
   localparam int ST_SIZE_LO = 8;
   // Header and address layout on the wire
   localparam logic [4:0] LAST_ADDR_BIT = 5'h1f;
   localparam int HDR_DIR = 30;
   localparam int HDR_SIZE_HI = 28;
   localparam int HDR_SIZE_LO = 23;
   localparam int HDR_WIN_HI = 22;
   localparam int HDR_WIN_LO = 15;
   localparam logic [7:0] OWN_WINDOW = 8'hd4;
   localparam logic [2:0] WAIT_WINDOW_LAST = 3'h7;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
   // Reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [31:0] TXDATA_RESET = 32'h0000_0000;

   typedef struct packed {
      logic csN;
      logic sclk;
      logic mosi;
   } pins_s;

   typedef struct packed {
      logic valid;
      logic [5:0] index;
      logic [7:0] data;
   } rx_byte_s;
endpackage : spi_frame_pkg

// *** spi_host_model.sv ***
// Purpose: Host-side mode 0 serial master issuing register-access frames.
// Assumes: HALF is half the link clock period.
// Notes: A frame stops early after stopAt bits, then deselects.
`timescale 1ns/1ps
module spi_host_model #(
   parameter realtime HALF = 62.5
) (
   output logic csN,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   input wire logic misoOe
);
   logic [7:0] txBuf [64];
   logic [7:0] rxBuf [64];
   int waitCount;
   logic junk = 1'b0;
   // A released line toggles so a stale level can never pass for data
   wire misoLine = misoOe ? miso : junk;
   always @(negedge sclk) junk <= ~junk;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   task automatic clockBit(input logic b, output logic s);
      mosi = b;
      #(HALF) sclk = 1'b1;
      s = misoLine;
      #(HALF) sclk = 1'b0;
   endtask : clockBit

   task automatic frame(input logic rd, input logic [5:0] sz, input logic [23:0] addr,
                        input int stopAt);
      logic [31:0] hdr;
      logic s;
      logic d;
      int n;
      hdr = {rd, 1'b0, sz, addr};
      n = 0;
      s = 1'b0;
      waitCount = 0;
      csN = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         if (n < stopAt) begin
            clockBit(hdr[i], d);
            n++;
         end
      end
      // Polling is capped so an absent device cannot hang the frame
      while (n < stopAt && s !== 1'b1 && waitCount < 16) begin
         clockBit(1'b0, s);
         n++;
         if (s !== 1'b1) begin
            waitCount++;
            repeat (7) clockBit(1'b0, d);
            n += 7;
         end
      end
      for (int k = 0; k <= sz; k++) begin
         for (int j = 7; j >= 0; j--) begin
            if (n < stopAt) begin
               clockBit(txBuf[k][j], s);
               rxBuf[k][j] = s;
               n++;
            end
         end
      end
      #(HALF) csN = 1'b1;
      #(HALF * 4);
   endtask : frame
endmodule : spi_host_model
